// File: hw/tmss_defines.vh
// tmss_defines.vh: status codes, control pattern bits and timing counts
// assumes a 100 MHz system clock; included by the sequencer only
`ifndef TMSS_DEFINES_VH
`define TMSS_DEFINES_VH
// ==========================================
// status codes, prescaler bits read as zero
`define TMSS_ST_START 8'h08
`define TMSS_ST_RSTART 8'h10
`define TMSS_ST_SLAW_ACK 8'h18
`define TMSS_ST_SLAW_NACK 8'h20
`define TMSS_ST_DATA_ACK 8'h28
`define TMSS_ST_DATA_NACK 8'h30
`define TMSS_ST_ARB_LOST 8'h38
`define TMSS_ST_SLAR_ACK 8'h40
`define TMSS_ST_SLAR_NACK 8'h48
`define TMSS_ST_RX_ACK 8'h50
`define TMSS_ST_RX_NACK 8'h58
`define TMSS_ST_IDLE 8'hf8
// ==========================================
// control register bit positions
`define TMSS_CTL_FLAG 7
`define TMSS_CTL_ACK 6
`define TMSS_CTL_START 5
`define TMSS_CTL_STOP 4
`define TMSS_CTL_WCOL 3
`define TMSS_CTL_EN 2
// ==========================================
// timing: a quarter of a serial clock period, in system cycles
`define TMSS_HALF_NS 5000
`define TMSS_CLK_NS 10
`define TMSS_HALF_CYC ((`TMSS_HALF_NS) / (`TMSS_CLK_NS))
`endif

// File: hw/tmss_sequencer.v
// tmss_sequencer.v: master status sequencer of a byte-oriented two-wire interface
// assumes open-drain scl/sda with pull-ups outside; pins are asynchronous to clk_sys_in
//
// Summary of operation
// - status 28: loaded byte sent, ack sampled
// - status 30 continues like status 28
// - start without stop sends repeated start
// - stop sends stop, stop bit self clears
// - start plus stop: stop then start
// - status 38, no start: release bus
// - status 38, start: wait free, start
// - start once bus free, status 08
// - read address gives 40, 48 or 38
// - status 40/50: receive, ack per enable
// - received byte held while flag set
// - status 48: only start/stop choices
// - status 10: address bit picks mode
// - repeated start keeps bus ownership
// - flag set stretches serial clock
// - data write with flag low collides
`timescale 1ns/1ps
`include "tmss_defines.vh"

module tmss_sequencer #(
  parameter HALF_CYC = `TMSS_HALF_CYC
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire ctl_wr_in,
  input wire [7:0] ctl_wdata_in,
  input wire data_wr_in,
  input wire [7:0] data_wdata_in,
  input wire scl_in,
  input wire sda_in,
  output wire scl_out,
  output wire scl_oe_n_out,
  output wire sda_out,
  output wire sda_oe_n_out,
  output reg [7:0] bus_data_reg_out,
  output reg [7:0] bus_status_code_out,
  output reg bus_event_flag_out,
  output reg write_collision_flag_out,
  output reg start_request_bit_out,
  output reg stop_request_bit_out,
  output reg ack_enable_bit_out,
  output reg interface_enable_bit_out,
  output reg master_receive_mode_out,
  output reg bus_busy_out
);

// ==========================================
// state codes
localparam [7:0] S_IDLE = 8'h01;
localparam [7:0] S_START = 8'h02;
localparam [7:0] S_BIT = 8'h04;
localparam [7:0] S_ACK = 8'h08;
localparam [7:0] S_STOP = 8'h10;
localparam [7:0] S_WAIT = 8'h20;
localparam [7:0] S_HOLD = 8'h40;
localparam [7:0] S_RSTART = 8'h80;

// ==========================================
// pin synchronisers: three stages, change counted when two and three agree
reg [2:0] scl_sync;
reg [2:0] sda_sync;
reg scl_f;
reg sda_f;
reg sda_f_d;
always @(posedge clk_sys_in or negedge nrst_in) begin
  if (!nrst_in) begin
    scl_sync <= 3'h7;
    sda_sync <= 3'h7;
    scl_f <= 1'b1;
    sda_f <= 1'b1;
    sda_f_d <= 1'b1;
  end else begin
    scl_sync <= {scl_sync[1:0], scl_in};
    sda_sync <= {sda_sync[1:0], sda_in};
    if (scl_sync[1] == scl_sync[2])
      scl_f <= scl_sync[2];
    if (sda_sync[1] == sda_sync[2])
      sda_f <= sda_sync[2];
    sda_f_d <= sda_f;
  end
end
wire start_seen = scl_f && sda_f_d && !sda_f;
wire stop_seen = scl_f && !sda_f_d && sda_f;

// ==========================================
// bus sequencer
reg [7:0] state;
reg [1:0] phase;
reg [15:0] tick;
reg [3:0] bit_cnt;
reg [7:0] shift;
reg scl_drv;
reg sda_drv;
reg is_addr;
reg stop_then_start;
reg nack_rx;

assign scl_out = 1'b0;
assign sda_out = 1'b0;
// scl held low whenever driven; flag set parks scl low
assign scl_oe_n_out = !scl_drv;
assign sda_oe_n_out = !sda_drv;

wire tick_done = (tick == 16'h0000);
// clock stretch by a slave: wait while scl released but still low
// bit phases release scl in phase 2, start/stop in phase 1; else high time shrinks
wire rel_phase = (state == S_BIT || state == S_ACK) ? (phase == 2'h2) : (phase == 2'h1);
wire stretched = rel_phase && !scl_drv && !scl_f;

wire ctl_flag = ctl_wr_in && ctl_wdata_in[`TMSS_CTL_FLAG];
wire ctl_sta = ctl_wdata_in[`TMSS_CTL_START];
wire ctl_sto = ctl_wdata_in[`TMSS_CTL_STOP];

always @(posedge clk_sys_in or negedge nrst_in) begin
  if (!nrst_in) begin
    state <= S_IDLE;
    phase <= 2'h0;
    tick <= 16'h0000;
    bit_cnt <= 4'h0;
    shift <= 8'h00;
    scl_drv <= 1'b0;
    sda_drv <= 1'b0;
    is_addr <= 1'b0;
    stop_then_start <= 1'b0;
    nack_rx <= 1'b0;
    bus_data_reg_out <= 8'h00;
    bus_status_code_out <= `TMSS_ST_IDLE;
    bus_event_flag_out <= 1'b0;
    write_collision_flag_out <= 1'b0;
    start_request_bit_out <= 1'b0;
    stop_request_bit_out <= 1'b0;
    ack_enable_bit_out <= 1'b0;
    interface_enable_bit_out <= 1'b0;
    master_receive_mode_out <= 1'b0;
    bus_busy_out <= 1'b0;
  end else begin
    // bus busy tracking from line conditions; our own start also marks it
    if (start_seen)
      bus_busy_out <= 1'b1;
    else if (stop_seen)
      bus_busy_out <= 1'b0;
    if (ctl_wr_in) begin
      ack_enable_bit_out <= ctl_wdata_in[`TMSS_CTL_ACK];
      start_request_bit_out <= ctl_sta;
      stop_request_bit_out <= ctl_sto;
      interface_enable_bit_out <= ctl_wdata_in[`TMSS_CTL_EN];
      write_collision_flag_out <= ctl_wdata_in[`TMSS_CTL_WCOL];
    end
    // data written only while flag set, else discarded
    if (data_wr_in) begin
      if (bus_event_flag_out)
        bus_data_reg_out <= data_wdata_in;
      else
        write_collision_flag_out <= 1'b1;
    end
    if (!tick_done && !stretched)
      tick <= tick - 16'h0001;
    case (state)
      S_IDLE: begin
        scl_drv <= 1'b0;
        sda_drv <= 1'b0;
        if (ctl_flag && ctl_sta && ctl_wdata_in[`TMSS_CTL_EN]) begin
          bus_event_flag_out <= 1'b0;
          state <= S_WAIT;
        end
      end
      S_WAIT: begin
        // start only once the bus is seen free
        if (!bus_busy_out && scl_f && sda_f) begin
          state <= S_START;
          phase <= 2'h0;
          tick <= HALF_CYC[15:0];
        end
      end
      S_START, S_RSTART: begin
        if (tick_done) begin
          phase <= phase + 2'h1;
          tick <= HALF_CYC[15:0];
          if (state == S_RSTART && phase == 2'h0) begin
            sda_drv <= 1'b0;
            scl_drv <= 1'b0;
          end else if (phase == 2'h1 || (state == S_START && phase == 2'h0)) begin
            sda_drv <= 1'b1;
          end else begin
            scl_drv <= 1'b1;
            state <= S_HOLD;
            bus_event_flag_out <= 1'b1;
            // status 08 or 10; ownership kept after repeated start
            bus_status_code_out <= (state == S_START) ? `TMSS_ST_START : `TMSS_ST_RSTART;
            start_request_bit_out <= 1'b0;
            is_addr <= 1'b1;
          end
        end
      end
      S_HOLD: begin
        // flag set: bus suspended with scl low
        scl_drv <= 1'b1;
        if (ctl_flag) begin
          bus_event_flag_out <= 1'b0;
          phase <= 2'h0;
          tick <= HALF_CYC[15:0];
          if (bus_status_code_out == `TMSS_ST_ARB_LOST) begin
            // release, or wait for free bus and restart
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
            master_receive_mode_out <= 1'b0;
            state <= ctl_sta ? S_WAIT : S_IDLE;
          end else if (ctl_sto) begin
            // stop, then start if also asked
            stop_then_start <= ctl_sta;
            state <= S_STOP;
            sda_drv <= 1'b1;
          end else if (ctl_sta) begin
            state <= S_RSTART;
          end else if (bus_status_code_out != `TMSS_ST_SLAR_NACK &&
                       bus_status_code_out != `TMSS_ST_RX_NACK) begin
            // address after start picks mode by direction bit
            if (is_addr)
              master_receive_mode_out <= bus_data_reg_out[0];
            // transmit loaded byte or receive next one
            shift <= bus_data_reg_out;
            bit_cnt <= 4'h8;
            state <= S_BIT;
          end else begin
            bus_event_flag_out <= 1'b1;
          end
        end
      end
      S_BIT, S_ACK: begin
        if (tick_done && !stretched) begin
          tick <= HALF_CYC[15:0];
          phase <= phase + 2'h1;
          if (phase == 2'h0) begin
            if (state == S_ACK)
              sda_drv <= (master_receive_mode_out && !is_addr) ? ack_enable_bit_out : 1'b0;
            else
              sda_drv <= (master_receive_mode_out && !is_addr) ? 1'b0 : !shift[7];
          end else if (phase == 2'h1) begin
            scl_drv <= 1'b0;
          end else if (phase == 2'h2) begin
            if (state == S_BIT) begin
              // lost arbitration: we released sda but line is low
              if (!(master_receive_mode_out && !is_addr) && !sda_drv && !sda_f) begin
                sda_drv <= 1'b0;
                state <= S_HOLD;
                bus_event_flag_out <= 1'b1;
                bus_status_code_out <= `TMSS_ST_ARB_LOST;
              end
              shift <= {shift[6:0], sda_f};
            end else begin
              nack_rx <= sda_f;
            end
          end else begin
            scl_drv <= 1'b1;
            phase <= 2'h0;
            if (state == S_BIT) begin
              bit_cnt <= bit_cnt - 4'h1;
              if (bit_cnt == 4'h1)
                state <= S_ACK;
            end else begin
              sda_drv <= 1'b0;
              state <= S_HOLD;
              bus_event_flag_out <= 1'b1;
              is_addr <= 1'b0;
              if (master_receive_mode_out && !is_addr) begin
                // received byte stays put while flag set
                bus_data_reg_out <= shift;
                bus_status_code_out <= ack_enable_bit_out ? `TMSS_ST_RX_ACK : `TMSS_ST_RX_NACK;
              end else if (is_addr) begin
                // status 40/48 or 18/20 from the sampled ack
                if (master_receive_mode_out)
                  bus_status_code_out <= nack_rx ? `TMSS_ST_SLAR_NACK : `TMSS_ST_SLAR_ACK;
                else
                  bus_status_code_out <= nack_rx ? `TMSS_ST_SLAW_NACK : `TMSS_ST_SLAW_ACK;
              end else begin
                bus_status_code_out <= nack_rx ? `TMSS_ST_DATA_NACK : `TMSS_ST_DATA_ACK;
              end
            end
          end
        end
      end
      S_STOP: begin
        if (tick_done) begin
          tick <= HALF_CYC[15:0];
          phase <= phase + 2'h1;
          if (phase == 2'h0) begin
            scl_drv <= 1'b0;
          end else if (phase == 2'h1) begin
            sda_drv <= 1'b0;
          end else begin
            // stop request cleared by hardware
            stop_request_bit_out <= 1'b0;
            master_receive_mode_out <= 1'b0;
            bus_status_code_out <= `TMSS_ST_IDLE;
            state <= stop_then_start ? S_WAIT : S_IDLE;
          end
        end
      end
      default: state <= S_IDLE;
    endcase
  end
end

endmodule // tmss_sequencer

// File: testbench/tb_top.sv
// tb_top.sv: self-checking bench for the master status sequencer
// assumes one slave model and a spare pull-down standing in for a rival master
`timescale 1ns/1ps
module tb_top;
  localparam [6:0] SLV = 7'h2a;
  reg clk_sys_in = 1'b0, nrst_in = 1'b0, ctl_wr_in = 1'b0, data_wr_in = 1'b0;
  reg nack = 1'b0, arb = 1'b0;
  reg [7:0] ctl_wdata_in = 8'h00, data_wdata_in = 8'h00, b;
  reg [7:0] rxq[$];
  wire scl_oe_n_out, sda_oe_n_out, pull_n, flag, wcol, stop_bit, rxm, busy;
  wire sta_bit, ack_bit, en_bit;
  wire [7:0] dreg, stat, got;
  wire scl = scl_oe_n_out;
  wire sda = sda_oe_n_out & pull_n & !arb;
  integer err_total = 0, check_count = 0, seed = 32'hd253, i, k, r;
  tmss_sequencer #(.HALF_CYC(4)) u_tmss_sequencer (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .ctl_wr_in(ctl_wr_in), .ctl_wdata_in(ctl_wdata_in),
    .data_wr_in(data_wr_in), .data_wdata_in(data_wdata_in), .scl_in(scl), .sda_in(sda),
    .scl_out(), .scl_oe_n_out(scl_oe_n_out), .sda_out(), .sda_oe_n_out(sda_oe_n_out),
    .bus_data_reg_out(dreg), .bus_status_code_out(stat), .bus_event_flag_out(flag),
    .write_collision_flag_out(wcol), .start_request_bit_out(sta_bit),
    .stop_request_bit_out(stop_bit), .ack_enable_bit_out(ack_bit),
    .interface_enable_bit_out(en_bit), .master_receive_mode_out(rxm),
    .bus_busy_out(busy));
  tmss_slave_model #(.ADDR(SLV), .BASE(8'h3c)) u_tmss_slave_model (.scl_in(scl), .sda_in(sda),
    .nack_in(nack), .sda_pull_n_out(pull_n), .got_out(got));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  // ==========================================
  // tasks
  task stop_test;
    begin
      if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // two edges per write, so back-to-back calls never double-drive a strobe
  task ctl(input [7:0] v);
    begin
      ctl_wdata_in = v; ctl_wr_in = 1'b1;
      @(posedge clk_sys_in); #1 ctl_wr_in = 1'b0;
      @(posedge clk_sys_in); #1;
    end
  endtask
  task dat(input [7:0] v);
    begin
      data_wdata_in = v; data_wr_in = 1'b1;
      @(posedge clk_sys_in); #1 data_wr_in = 1'b0;
      @(posedge clk_sys_in); #1;
    end
  endtask
  task wflag(input [7:0] st);
    begin
      i = 0;
      while (flag !== 1'b1 && i < 5000) begin @(posedge clk_sys_in); #1 i = i + 1; end
      if (i == 5000) begin err_total = err_total + 1; stop_test; end
      chk(stat, st);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    #1;
    repeat (12) @(posedge clk_sys_in);
    #1 nrst_in = 1'b1;
    dat(8'h55); chk({7'h00, wcol}, 8'h01);
    ctl(8'ha4); wflag(8'h08);
    chk({5'h00, sta_bit, ack_bit, en_bit}, 8'h01);
    dat({SLV, 1'b0}); ctl(8'h84); wflag(8'h18);
    for (k = 0; k < 3; k = k + 1) begin
      r = $random(seed); b = r[7:0]; nack = (k == 1);
      dat(b); ctl(8'h84); wflag(nack ? 8'h30 : 8'h28);
      chk(got, b);
    end
    nack = 1'b0;
    ctl(8'ha4); wflag(8'h10);
    chk({7'h00, busy}, 8'h01);
    dat({SLV, 1'b1}); ctl(8'h84); wflag(8'h40);
    chk({7'h00, rxm}, 8'h01);
    rxq.push_back(8'h3c); rxq.push_back(8'h3d);
    ctl(8'hc4); wflag(8'h50); chk(dreg, rxq.pop_front());
    chk({5'h00, sta_bit, ack_bit, en_bit}, 8'h03);
    ctl(8'h84); wflag(8'h58); chk(dreg, rxq.pop_front());
    ctl(8'hb4); wflag(8'h08); chk({7'h00, stop_bit}, 8'h00);
    dat({SLV + 7'h01, 1'b1}); ctl(8'h84); wflag(8'h48);
    ctl(8'h94); i = 0;
    while (busy !== 1'b0 && i < 5000) begin @(posedge clk_sys_in); #1 i = i + 1; end
    if (i == 5000) begin err_total = err_total + 1; stop_test; end
    chk(stat, 8'hf8); chk({7'h00, flag, stop_bit}, 8'h00);
    ctl(8'ha4); wflag(8'h08); dat({SLV, 1'b0}); ctl(8'h84); wflag(8'h18);
    // rival master holds sda low while our first bit is a one
    arb = 1'b1; dat(8'hff); ctl(8'h84); wflag(8'h38);
    // restart must hold off until the rival ends with a stop
    ctl(8'ha4); repeat (10) @(posedge clk_sys_in);
    #1 chk({7'h00, flag}, 8'h00); arb = 1'b0; wflag(8'h08);
    dat({SLV, 1'b0}); ctl(8'h84); wflag(8'h18);
    arb = 1'b1; dat(8'hff); ctl(8'h84); wflag(8'h38); arb = 1'b0;
    ctl(8'h84); repeat (10) @(posedge clk_sys_in);
    #1 chk({6'h00, scl_oe_n_out, sda_oe_n_out}, 8'h03);
    stop_test;
  end
endmodule // tb_top

// File: testbench/tmss_sequencer_sva.sv
// tmss_sequencer_sva.sv: port checker for the master status sequencer
// assumes it is bound to the sequencer and that HALF_CYC keeps waits short
`timescale 1ns/1ps
module tmss_sequencer_chk #(
  parameter HALF_CYC = 500
) (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire ctl_wr_in,
  input wire [7:0] ctl_wdata_in,
  input wire data_wr_in,
  input wire scl_oe_n_out,
  input wire sda_oe_n_out,
  input wire [7:0] bus_data_reg_out,
  input wire [7:0] bus_status_code_out,
  input wire bus_event_flag_out,
  input wire write_collision_flag_out,
  input wire stop_request_bit_out,
  input wire master_receive_mode_out
);
  // capped, the tools slow down on long ranges
  localparam int LIM = (3 * HALF_CYC + 8 > 1000) ? 1000 : 3 * HALF_CYC + 8;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================
  // assertions
  property p_coll; data_wr_in && !bus_event_flag_out |=> write_collision_flag_out; endproperty
  a_coll: assert property (p_coll) else $error("collision flag not set");
  property p_hold;
    bus_event_flag_out && !ctl_wr_in && !data_wr_in |=> $stable(bus_data_reg_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data changed while flag set");
  property p_stretch;
    bus_event_flag_out [*2] ##0 (bus_status_code_out != 8'h38) |-> !scl_oe_n_out;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held low");
  property p_stop; stop_request_bit_out |-> ##[1:LIM] !stop_request_bit_out; endproperty
  a_stop: assert property (p_stop) else $error("stop request not cleared");
  property p_clear;
    ctl_wr_in && ctl_wdata_in[7] && bus_event_flag_out
      && !(bus_status_code_out inside {8'h48, 8'h58}) |=> !bus_event_flag_out;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_legal;
    $rose(bus_event_flag_out) |-> bus_status_code_out inside
      {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58};
  endproperty
  a_legal: assert property (p_legal) else $error("bad status code");
  property p_rxmode;
    $rose(bus_event_flag_out) && bus_status_code_out inside {8'h40, 8'h48, 8'h50, 8'h58}
      |-> master_receive_mode_out;
  endproperty
  a_rxmode: assert property (p_rxmode) else $error("receive mode not set");
  property p_start;
    $fell(sda_oe_n_out) && scl_oe_n_out |-> ##[1:LIM] bus_event_flag_out
      && bus_status_code_out inside {8'h08, 8'h10};
  endproperty
  a_start: assert property (p_start) else $error("start without status");
endmodule // tmss_sequencer_chk
bind tmss_sequencer tmss_sequencer_chk #(.HALF_CYC(HALF_CYC)) u_tmss_sequencer_chk (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ctl_wr_in(ctl_wr_in),
  .ctl_wdata_in(ctl_wdata_in), .data_wr_in(data_wr_in), .scl_oe_n_out(scl_oe_n_out),
  .sda_oe_n_out(sda_oe_n_out), .bus_data_reg_out(bus_data_reg_out),
  .bus_status_code_out(bus_status_code_out), .bus_event_flag_out(bus_event_flag_out),
  .write_collision_flag_out(write_collision_flag_out),
  .stop_request_bit_out(stop_request_bit_out),
  .master_receive_mode_out(master_receive_mode_out));

// File: testbench/tmss_slave_model.sv
// tmss_slave_model.sv: behavioural slave on the two-wire bus
// assumes resolved line levels in; sets its sda pull on scl falling edges, releases it on a start
`timescale 1ns/1ps
module tmss_slave_model #(
  parameter [6:0] ADDR = 7'h2a,
  parameter [7:0] BASE = 8'h3c
) (
  input wire scl_in,
  input wire sda_in,
  input wire nack_in,
  output reg sda_pull_n_out,
  output reg [7:0] got_out
);
  integer bitn = 0;
  reg [7:0] sh = 8'h00;
  reg [7:0] tx = 8'h00;
  reg rd = 1'b0, sel = 1'b0, adr = 1'b0, ack = 1'b0, wa = 1'b0, mack = 1'b0;
  initial sda_pull_n_out = 1'b1;
  initial got_out = 8'h00;
  // ==========================================
  // framing
  always @(negedge sda_in) if (scl_in === 1'b1) begin
    bitn = 0; adr = 1'b1; ack = 1'b0; sel = 1'b0; tx = BASE; sda_pull_n_out = 1'b1;
  end
  always @(posedge sda_in) if (scl_in === 1'b1) sel = 1'b0;
  always @(posedge scl_in) begin
    if (ack) mack = !sda_in;
    else begin
      sh = {sh[6:0], sda_in};
      bitn = bitn + 1;
    end
  end
  always @(negedge scl_in) begin
    if (ack) begin
      ack = 1'b0; bitn = 0;
      if (rd && sel && !wa && !mack) sel = 1'b0;
      if (rd && sel && !wa) tx = tx + 8'h01;
      sda_pull_n_out = !(rd && sel) | tx[7];
    end else if (bitn == 8) begin
      ack = 1'b1; wa = adr;
      if (!adr && sel && !rd) got_out = sh;
      if (adr) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        adr = 1'b0;
      end
      // data nack on request only
      sda_pull_n_out = !(sel && (wa || !rd) && !(nack_in && !wa));
    end else sda_pull_n_out = !(rd && sel && !adr) | tx[7 - bitn];
  end
endmodule // tmss_slave_model
